/* File: hw/pin_mux_consts.vh */
// Constants for the parallel port and flag pin multiplexer
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

// System control bit positions
`define SYSTEM_CONTROL_REG_EXT_INTERRUPT_IN0_EN_BIT   16
`define SYSTEM_CONTROL_REG_EXT_INTERRUPT_IN1_EN_BIT   17
`define SYSTEM_CONTROL_REG_EXT_INTERRUPT_IN2_EN_BIT   18
`define SYSTEM_CONTROL_REG_TIMER_EXPIRED_OUT_EN_BIT 19
`define SYSTEM_CONTROL_REG_FLAG_EN_BIT   20
`define SYSTEM_CONTROL_REG_WIDTH         32

// Port widths
`define PAR_PINS_W           16
`define EXT_ADDR_W           24
`define GP_FLAGS_W           4

// Reset values
`define ALE_POL_RESET        1'h1
`define BYTE_MODE_RESET      1'h0

`endif

/* File: hw/flag_pin_cell.v */
// One general-purpose flag pin with its alternate duties
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_consts.vh"

module flag_pin_cell (
   // Clock and reset
   input  wire sys_clk_i,
   input  wire nrst_i,
   // Selection
   input  wire gp_dir_out_i,
   input  wire gp_value_i,
   input  wire alt_irq_en_i,
   input  wire alt_out_en_i,
   input  wire alt_out_val_i,
   input  wire ss_en_i,
   input  wire ss_val_i,
   // Pin
   input  wire pin_i,
   output reg  pin_o,
   output reg  pin_oe_o,
   // Core side
   output reg  flag_in_o,
   output reg  irq_o
);

   reg sync_a;
   reg sync_b;
   reg next_oe;
   reg next_val;

   // Alternate functions override direction
   always @* begin
      next_oe  = 1'b0;
      next_val = 1'b0;
      if (alt_irq_en_i) begin
         next_oe = 1'b0;
      end else if (alt_out_en_i) begin
         next_oe  = 1'b1;
         next_val = alt_out_val_i;
      end else if (ss_en_i) begin
         next_oe  = 1'b1;
         next_val = ss_val_i;
      end else if (gp_dir_out_i) begin
         next_oe  = 1'b1;
         next_val = gp_value_i;
      end
   end

   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_a    <= 1'b0;
         sync_b    <= 1'b0;
         pin_o     <= 1'b0;
         pin_oe_o  <= 1'b0;
         flag_in_o <= 1'b0;
         irq_o     <= 1'b0;
      end else begin
         sync_a    <= pin_i;
         sync_b    <= sync_a;
         pin_o     <= next_val;
         pin_oe_o  <= next_oe;
         flag_in_o <= sync_b;
         irq_o     <= alt_irq_en_i & sync_b;
      end
   end

endmodule // flag_pin_cell
`default_nettype wire

/* File: hw/parallel_port_and_flag_pin_mux.v */
// Parallel address/data port and flag pin multiplexer
// How it works
// - Sixteen pins carry address then data; latch strobe marks the address phase.
// - Byte mode or halfword mode chosen by an input bit.
// - Byte mode: strobe issued when address bits 23..8 change; board latches them.
// - Halfword mode: strobe issued when address bits 15..0 change; board latches them.
// - Flag enable bit 20 with port disabled turns the pins into flags.
// - Read strobe low during reads, high while pins are flags.
// - Write strobe low during writes, high while pins are flags.
// - Latch strobe active high after reset, polarity selectable, idle in flag mode.
// - In reset latch strobe low, read and write strobes high.
// - Each flag pin is input or output by control bits.
// - Any flag pin can drive SPI slave select in master mode.
// - During SPI master boot flag pin zero is the slave select.
// - Control bit 16 makes flag pin zero interrupt input zero.
// - Control bit 17 makes flag pin one interrupt input one.
// - Control bit 18 makes flag pin two interrupt input two.
// - Control bit 19 makes flag pin three drive timer expired.
// - Pins used as inputs feed channel zero of the input data port.
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_consts.vh"

module parallel_port_and_flag_pin_mux (
   // Clock and reset
   input  wire                       sys_clk_i,
   input  wire                       nrst_i,
   // Configuration
   input  wire [`SYSTEM_CONTROL_REG_WIDTH-1:0]   system_control_reg_i,
   input  wire                       port_enable_i,
   input  wire                       byte_mode_i,
   input  wire                       ale_active_low_i,
   // Transfer request
   input  wire                       req_valid_i,
   input  wire                       req_write_i,
   input  wire [`EXT_ADDR_W-1:0]     req_addr_i,
   input  wire [`PAR_PINS_W-1:0]     req_wdata_i,
   output reg                        req_ready_o,
   output reg                        rdata_valid_o,
   output reg  [`PAR_PINS_W-1:0]     rdata_o,
   // Parallel pins
   input  wire [`PAR_PINS_W-1:0]     par_addr_data_pins_i,
   output reg  [`PAR_PINS_W-1:0]     par_addr_data_pins_o,
   output reg  [`PAR_PINS_W-1:0]     par_addr_data_pins_oe_o,
   output reg                        ale_o,
   output reg                        rd_n_o,
   output reg                        wr_n_o,
   // Port flags
   input  wire [`PAR_PINS_W-1:0]     port_flag_dir_out_i,
   input  wire [`PAR_PINS_W-1:0]     port_flag_value_i,
   output reg  [`PAR_PINS_W-1:0]     port_flag_pins_in_o,
   // Input data port channel 0
   output reg  [`PAR_PINS_W-1:0]     input_data_port_ch0_o,
   // General-purpose flags
   input  wire [`GP_FLAGS_W-1:0]     gp_flag_dir_out_i,
   input  wire [`GP_FLAGS_W-1:0]     gp_flag_value_i,
   input  wire                       spi_master_i,
   input  wire                       spi_boot_i,
   input  wire [`GP_FLAGS_W-1:0]     spi_ss_sel_i,
   input  wire                       spi_ss_n_i,
   input  wire                       timer_expired_i,
   input  wire [`GP_FLAGS_W-1:0]     gp_flag_pins_i,
   output wire [`GP_FLAGS_W-1:0]     gp_flag_pins_o,
   output wire [`GP_FLAGS_W-1:0]     gp_flag_pins_oe_o,
   output wire [`GP_FLAGS_W-1:0]     gp_flag_pins_in_o,
   output reg                        ext_interrupt_in0_o,
   output reg                        ext_interrupt_in1_o,
   output reg                        ext_interrupt_in2_o
);

   // ****************************************************************
   // States
   // ****************************************************************
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_ADDR = 5'h02;
   localparam [4:0] ST_HOLD = 5'h04;
   localparam [4:0] ST_DATA = 5'h08;
   localparam [4:0] ST_DONE = 5'h10;

   reg  [4:0]              state;
   reg  [4:0]              next_state;
   reg  [`PAR_PINS_W-1:0]  sync_a;
   reg  [`PAR_PINS_W-1:0]  sync_b;
   reg  [`EXT_ADDR_W-1:0]  last_addr;
   reg                     addr_known;
   reg                     cur_write;
   reg  [`EXT_ADDR_W-1:0]  cur_addr;
   reg  [`PAR_PINS_W-1:0]  cur_wdata;
   wire                    flag_mode;
   wire [`GP_FLAGS_W-1:0]  gp_irq;
   wire [`GP_FLAGS_W-1:0]  alt_irq_en;
   wire [`GP_FLAGS_W-1:0]  alt_out_en;
   wire [`GP_FLAGS_W-1:0]  ss_en;

   // Address bits that the board latch holds in this mode: 23..8 in byte mode, 15..0 in halfword mode
   function [`PAR_PINS_W-1:0] latched_part;
      input                    byte_mode;
      input [`EXT_ADDR_W-1:0]  addr;
      begin
         if (byte_mode) begin
            latched_part = addr[`EXT_ADDR_W-1:8];
         end else begin
            latched_part = addr[`PAR_PINS_W-1:0];
         end
      end
   endfunction

   assign flag_mode = system_control_reg_i[`SYSTEM_CONTROL_REG_FLAG_EN_BIT] & ~port_enable_i;

   // ****************************************************************
   // Transfer sequencer
   // ****************************************************************
   // New latch cycle when the latched address part moved or is not yet known; saves a phase
   wire need_ale = ~addr_known |
                   (latched_part(byte_mode_i, req_addr_i) !=
                    latched_part(byte_mode_i, last_addr));

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (req_valid_i && port_enable_i && !flag_mode) begin
               if (need_ale) begin
                  next_state = ST_ADDR;
               end else begin
                  next_state = ST_DATA;
               end
            end
         end
         ST_ADDR: begin
            next_state = ST_HOLD;
         end
         ST_HOLD: begin
            next_state = ST_DATA;
         end
         ST_DATA: begin
            next_state = ST_DONE;
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state      <= ST_IDLE;
         last_addr  <= {`EXT_ADDR_W{1'b0}};
         addr_known <= 1'b0;
         cur_write  <= 1'b0;
         cur_addr   <= {`EXT_ADDR_W{1'b0}};
         cur_wdata  <= {`PAR_PINS_W{1'b0}};
      end else begin
         state <= next_state;
         if (state == ST_IDLE && next_state != ST_IDLE) begin
            cur_write  <= req_write_i;
            cur_addr   <= req_addr_i;
            cur_wdata  <= req_wdata_i;
            last_addr  <= req_addr_i;
            addr_known <= 1'b1;
         end
         if (flag_mode) begin
            addr_known <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Pin outputs
   // ****************************************************************
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_a                  <= {`PAR_PINS_W{1'b0}};
         sync_b                  <= {`PAR_PINS_W{1'b0}};
         par_addr_data_pins_o    <= {`PAR_PINS_W{1'b0}};
         par_addr_data_pins_oe_o <= {`PAR_PINS_W{1'b0}};
         ale_o                   <= 1'b0;
         rd_n_o                  <= 1'b1;
         wr_n_o                  <= 1'b1;
         req_ready_o             <= 1'b0;
         rdata_valid_o           <= 1'b0;
         rdata_o                 <= {`PAR_PINS_W{1'b0}};
         port_flag_pins_in_o     <= {`PAR_PINS_W{1'b0}};
         input_data_port_ch0_o   <= {`PAR_PINS_W{1'b0}};
         ext_interrupt_in0_o     <= 1'b0;
         ext_interrupt_in1_o     <= 1'b0;
         ext_interrupt_in2_o     <= 1'b0;
      end else begin
         sync_a <= par_addr_data_pins_i;
         sync_b <= sync_a;
         req_ready_o   <= (next_state == ST_IDLE) & port_enable_i & ~flag_mode;
         rdata_valid_o <= 1'b0;
         // Strobe idles at the inactive level of the chosen polarity
         ale_o  <= ale_active_low_i;
         rd_n_o <= 1'b1;
         wr_n_o <= 1'b1;
         if (flag_mode) begin
            ale_o                   <= ale_active_low_i;
            par_addr_data_pins_o    <= port_flag_value_i;
            par_addr_data_pins_oe_o <= port_flag_dir_out_i;
         end else begin
            case (next_state)
               ST_ADDR: begin
                  par_addr_data_pins_o    <= latched_part(byte_mode_i, req_addr_i);
                  par_addr_data_pins_oe_o <= {`PAR_PINS_W{1'b1}};
                  ale_o                   <= ~ale_active_low_i;
               end
               ST_HOLD: begin
                  par_addr_data_pins_oe_o <= {`PAR_PINS_W{1'b1}};
               end
               ST_DATA, ST_DONE: begin
                  par_addr_data_pins_o    <= cur_wdata;
                  par_addr_data_pins_oe_o <= {`PAR_PINS_W{cur_write}};
                  if (state == ST_IDLE) begin
                     par_addr_data_pins_o    <= req_wdata_i;
                     par_addr_data_pins_oe_o <= {`PAR_PINS_W{req_write_i}};
                  end
                  if (next_state == ST_DATA) begin
                     rd_n_o <= (state == ST_IDLE) ? req_write_i : cur_write;
                     wr_n_o <= (state == ST_IDLE) ? ~req_write_i : ~cur_write;
                  end
               end
               default: begin
                  par_addr_data_pins_oe_o <= {`PAR_PINS_W{1'b0}};
               end
            endcase
         end
         // Sample read data at end of strobe; byte mode uses low lane
         if (state == ST_DATA && !cur_write) begin
            rdata_valid_o <= 1'b1;
            rdata_o <= byte_mode_i ? {8'h00, sync_b[7:0]} : sync_b;
         end
         port_flag_pins_in_o   <= sync_b;
         input_data_port_ch0_o <= sync_b;
         ext_interrupt_in0_o   <= gp_irq[0];
         ext_interrupt_in1_o   <= gp_irq[1];
         ext_interrupt_in2_o   <= gp_irq[2];
      end
   end

   // ****************************************************************
   // General-purpose flag pins
   // ****************************************************************
   assign alt_irq_en = {1'b0,
                        system_control_reg_i[`SYSTEM_CONTROL_REG_EXT_INTERRUPT_IN2_EN_BIT],
                        system_control_reg_i[`SYSTEM_CONTROL_REG_EXT_INTERRUPT_IN1_EN_BIT],
                        system_control_reg_i[`SYSTEM_CONTROL_REG_EXT_INTERRUPT_IN0_EN_BIT]};
   assign alt_out_en = {system_control_reg_i[`SYSTEM_CONTROL_REG_TIMER_EXPIRED_OUT_EN_BIT], 3'h0};
   // Boot forces flag pin zero as select regardless of the selection
   assign ss_en = spi_boot_i ? 4'h1 : (spi_master_i ? spi_ss_sel_i : 4'h0);

   genvar g;
   generate
      for (g = 0; g < `GP_FLAGS_W; g = g + 1) begin : gp_flag
         flag_pin_cell u_cell (
            .sys_clk_i     (sys_clk_i),
            .nrst_i        (nrst_i),
            .gp_dir_out_i  (gp_flag_dir_out_i[g]),
            .gp_value_i    (gp_flag_value_i[g]),
            .alt_irq_en_i  (alt_irq_en[g]),
            .alt_out_en_i  (alt_out_en[g]),
            .alt_out_val_i (timer_expired_i),
            .ss_en_i       (ss_en[g]),
            .ss_val_i      (spi_ss_n_i),
            .pin_i         (gp_flag_pins_i[g]),
            .pin_o         (gp_flag_pins_o[g]),
            .pin_oe_o      (gp_flag_pins_oe_o[g]),
            .flag_in_o     (gp_flag_pins_in_o[g]),
            .irq_o         (gp_irq[g])
         );
      end
   endgenerate

endmodule // parallel_port_and_flag_pin_mux
`default_nettype wire

/* File: tb/pin_mux_monitor.sv */
// Concurrent checks on the pin multiplexer ports
`timescale 1ns/1ns
`default_nettype none
module pin_mux_monitor (
   // Clock, reset and configuration
   input wire logic        sys_clk_i,
   input wire logic        nrst_i,
   input wire logic [31:0] system_control_reg_i,
   input wire logic        port_enable_i,
   input wire logic        ale_active_low_i,
   input wire logic        timer_expired_i,
   // Port outputs
   input wire logic        req_ready_o,
   input wire logic        rdata_valid_o,
   input wire logic        ale_o,
   input wire logic        rd_n_o,
   input wire logic        wr_n_o,
   // Flag outputs
   input wire logic [3:0]  gp_flag_pins_o,
   input wire logic [3:0]  gp_flag_pins_oe_o,
   input wire logic        ext_interrupt_in0_o
);
   wire logic fl = system_control_reg_i[20] & ~port_enable_i;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   // Polarity must be settled, else a just-flipped idle level looks active
   sequence s_ale; (ale_o != ale_active_low_i) && $stable(ale_active_low_i); endsequence
   sequence s_strobe; !rd_n_o || !wr_n_o; endsequence
   sequence s_rd_done; rd_n_o && rdata_valid_o; endsequence
   property p_ale_strobe; s_ale |-> ##2 s_strobe; endproperty
   a_ale_strobe: assert property (p_ale_strobe) else $error("no strobe after latch");
   property p_wr_one; $fell(wr_n_o) |=> wr_n_o; endproperty
   a_wr_one: assert property (p_wr_one) else $error("write strobe too long");
   property p_rd_one; $fell(rd_n_o) |=> s_rd_done; endproperty
   a_rd_one: assert property (p_rd_one) else $error("read not completed");
   property p_flag_strobes; fl && $past(fl) && $past(fl, 2) |-> rd_n_o && wr_n_o; endproperty
   a_flag_strobes: assert property (p_flag_strobes) else $error("strobe in flag mode");
   property p_flag_ale; fl && $past(fl) && $stable(ale_active_low_i) |-> ale_o == ale_active_low_i;
   endproperty
   a_flag_ale: assert property (p_flag_ale) else $error("latch strobe in flag mode");
   property p_flag_refused; fl && $past(fl) |-> !req_ready_o; endproperty
   a_flag_refused: assert property (p_flag_refused) else $error("ready in flag mode");
   property p_ready_idle; req_ready_o |-> rd_n_o && wr_n_o && !rdata_valid_o; endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("strobe while idle");
   property p_irq_oe;
      (system_control_reg_i[18:16] & $past(system_control_reg_i[18:16])) != 3'h0
      |-> (system_control_reg_i[18:16] & gp_flag_pins_oe_o[2:0]) == 3'h0;
   endproperty
   a_irq_oe: assert property (p_irq_oe) else $error("interrupt flag driven");
   property p_timer_expired_out;
      system_control_reg_i[19] && $past(system_control_reg_i[19]) && $stable(timer_expired_i)
      |-> gp_flag_pins_oe_o[3] && gp_flag_pins_o[3] == timer_expired_i;
   endproperty
   a_timer_expired_out: assert property (p_timer_expired_out) else $error("timer flag wrong");
   property p_irq_off;
      !system_control_reg_i[16] && !$past(system_control_reg_i[16], 2) |-> !ext_interrupt_in0_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
endmodule // pin_mux_monitor
`default_nettype wire

/* File: tb/ext_mem_model.sv */
// External address latch and memory on the parallel pins
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
   // Pins
   input  wire logic        clk_i,
   input  wire logic        ale_act_i,
   input  wire logic        wr_n_i,
   input  wire logic        sel_i,
   input  wire logic [15:0] pins_i,
   output var  logic [15:0] pins_o,
   output var  logic [15:0] hold_o
);
   logic [15:0] mem [0:255];
   logic [15:0] last;
   always @(posedge clk_i) begin
      last <= pins_i;
      if (ale_act_i) hold_o <= pins_i;
      if (!wr_n_i) mem[hold_o[7:0]] <= pins_i;
   end
   // Deselected: no stale value, inverse of last level instead
   always @* pins_o = sel_i ? mem[hold_o[7:0]] : ~last;
endmodule // ext_mem_model
`default_nettype wire

/* File: tb/parallel_port_and_flag_pin_mux_tb.sv */
// Testbench for the parallel port and flag pin multiplexer
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_consts.vh"
module parallel_port_and_flag_pin_mux_tb;
   logic clk, rst_n, pen, bm, alp, rv, rw, sm, sb, ssn, tx, use_tb;
   logic [31:0] sc;
   logic [23:0] ra;
   logic [15:0] rwd, fdir, fval, tbp, pa, pd;
   logic [3:0]  gdir, gval, ssel, gpi;
   wire logic   rdy, rdv, ale, rdn, wrn, i0, i1, i2;
   wire logic [15:0] rdat, po, poe, pfi, input_data_port, mp, hold;
   wire logic [3:0]  go, goe, gin;
   wire logic [15:0] pin = (po & poe) | (~poe & (use_tb ? tbp : mp));
   wire logic [3:0]  gpin = (go & goe) | (~goe & gpi);
   int err_total, n_compared, na;
   parallel_port_and_flag_pin_mux i_dut (.sys_clk_i(clk), .nrst_i(rst_n),
      .system_control_reg_i(sc), .port_enable_i(pen), .byte_mode_i(bm), .ale_active_low_i(alp),
      .req_valid_i(rv), .req_write_i(rw), .req_addr_i(ra), .req_wdata_i(rwd),
      .req_ready_o(rdy), .rdata_valid_o(rdv), .rdata_o(rdat), .par_addr_data_pins_i(pin),
      .par_addr_data_pins_o(po), .par_addr_data_pins_oe_o(poe), .ale_o(ale), .rd_n_o(rdn),
      .wr_n_o(wrn), .port_flag_dir_out_i(fdir), .port_flag_value_i(fval),
      .port_flag_pins_in_o(pfi), .input_data_port_ch0_o(input_data_port), .gp_flag_dir_out_i(gdir),
      .gp_flag_value_i(gval), .spi_master_i(sm), .spi_boot_i(sb), .spi_ss_sel_i(ssel),
      .spi_ss_n_i(ssn), .timer_expired_i(tx), .gp_flag_pins_i(gpin), .gp_flag_pins_o(go),
      .gp_flag_pins_oe_o(goe), .gp_flag_pins_in_o(gin), .ext_interrupt_in0_o(i0),
      .ext_interrupt_in1_o(i1), .ext_interrupt_in2_o(i2));
   ext_mem_model i_mem (.clk_i(clk), .ale_act_i(ale ^ alp), .wr_n_i(wrn), .sel_i(pen),
      .pins_i(pin), .pins_o(mp), .hold_o(hold));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One transfer; counts latch strobes, keeps address and data seen
   task xfer(input logic w, input logic [23:0] a, input logic [15:0] d);
      int i;
      na = 0;
      i = 0;
      while (rdy !== 1'b1 && i < 20) begin
         @(negedge clk);
         i++;
      end
      // Ready never came: counts as a mismatch
      if (i == 20) chk({15'h0, rdy}, 16'h0001);
      rv = 1;
      rw = w;
      ra = a;
      rwd = d;
      @(negedge clk);
      rv = 0;
      for (i = 0; i < 6; i++) begin
         if (ale !== alp) begin
            na++;
            pa = po;
         end
         if (wrn === 1'b0) pd = po;
         if (rdv === 1'b1) pd = rdat;
         @(negedge clk);
      end
      chk({15'h0, rdy}, 16'h0001);
   endtask
   task end_sim;
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #20000;
      err_total++;
      end_sim();
   end
   initial begin
      {rst_n, bm, alp, rv, rw, sm, sb, ssn, tx, use_tb} = '0;
      {sc, ra, rwd, fdir, fval, tbp, gdir, gval, ssel, gpi} = '0;
      pen = 1;
      repeat (4) @(negedge clk);
      chk({ale, rdn, wrn}, 16'h0003);
      rst_n = 1;
      xfer(1, 24'h000012, 16'hA5C3);
      chk(na, 1); chk(pa, 16'h0012); chk(pd, 16'hA5C3); chk(hold, 16'h0012);
      xfer(1, 24'h000012, 16'h5A3C);
      chk(na, 0);
      xfer(0, 24'h000012, 16'h0000);
      chk(na, 0); chk(pd, 16'h5A3C);
      xfer(1, 24'h000013, 16'h1234);
      chk(na, 1);
      $display("halfword test done");
      bm = 1;
      xfer(1, 24'h123456, 16'h0077);
      chk(na, 1); chk(pa, 16'h1234); chk(hold, 16'h1234);
      xfer(1, 24'h1234A0, 16'h0011);
      chk(na, 0);
      alp = 1;
      repeat (2) @(negedge clk);
      chk(ale, 1);
      xfer(1, 24'h1236A0, 16'h0022);
      chk(na, 1);
      {alp, bm} = 2'b00;
      $display("byte and polarity test done");
      sc = 32'h0010_0000;
      pen = 0;
      use_tb = 1;
      fdir = 16'h00FF;
      fval = 16'h00A5;
      tbp = 16'h3C00;
      repeat (4) @(negedge clk);
      chk(rdy, 0); chk({ale, rdn, wrn}, 16'h0003); chk(poe, 16'h00FF);
      chk(pfi, 16'h3CA5); chk(input_data_port, 16'h3CA5);
      {sc, pen, use_tb} = {32'h0, 2'b10};
      xfer(1, 24'h000013, 16'h0001);
      chk(na, 1);
      $display("flag mode test done");
      gdir = 4'h3;
      gval = 4'h1;
      gpi = 4'hA;
      repeat (4) @(negedge clk);
      chk(goe, 16'h0003); chk(go & 4'h3, 16'h0001); chk(gin, 16'h0009);
      sc = 32'h000F_0000;
      tx = 1;
      gpi = 4'h5;
      repeat (5) @(negedge clk);
      chk(goe, 16'h0008); chk(go[3], 1); chk({i2, i1, i0}, 16'h0005);
      gpi = 4'h2;
      repeat (5) @(negedge clk);
      chk({i2, i1, i0}, 16'h0002);
      {sc, gdir, sm, ssel} = {32'h0, 4'h0, 1'b1, 4'h4};
      repeat (3) @(negedge clk);
      chk(goe, 16'h0004); chk(go[2], 0);
      {sb, ssel, ssn} = {1'b1, 4'h0, 1'b1};
      repeat (3) @(negedge clk);
      chk(goe[0], 1); chk(go[0], 1);
      $display("flag pin test done");
      end_sim();
   end
endmodule // parallel_port_and_flag_pin_mux_tb
bind parallel_port_and_flag_pin_mux pin_mux_monitor i_mon (.sys_clk_i(sys_clk_i),
   .nrst_i(nrst_i), .system_control_reg_i(system_control_reg_i), .port_enable_i(port_enable_i),
   .ale_active_low_i(ale_active_low_i), .timer_expired_i(timer_expired_i),
   .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o), .ale_o(ale_o), .rd_n_o(rd_n_o),
   .wr_n_o(wr_n_o), .gp_flag_pins_o(gp_flag_pins_o), .gp_flag_pins_oe_o(gp_flag_pins_oe_o),
   .ext_interrupt_in0_o(ext_interrupt_in0_o));
`default_nettype wire
